// *** hw/tpp_pkg.sv ***
package tpp_pkg;

    // ------------------------------------------------------------
    // Register port geometry
    // ------------------------------------------------------------
    localparam int TPP_ADDR_W = 16;
    localparam int TPP_DATA_W = 16;
    localparam int TPP_TYPE_W = 6;

    // Leading address nibble that marks the managed device space
    localparam logic [3:0] TPP_SPACE_NIBBLE = 4'h1;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] TPP_ADDR_CONTROL_ONE = 16'h1000;
    localparam logic [15:0] TPP_ADDR_CONTROL_TWO = 16'h1007;
    localparam logic [15:0] TPP_ADDR_TRANSMIT_OFF = 16'h1009;
    localparam logic [15:0] TPP_ADDR_EXT_CAP_TWO = 16'h100b;
    localparam logic [15:0] TPP_ADDR_T1_EXT_CAP = 16'h1012;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TPP_RESET_BIT = 15;
    localparam int TPP_TYPE_MSB = 5;
    localparam int TPP_TYPE_LSB = 0;
    localparam int TPP_TXOFF_BIT = 0;
    localparam int TPP_T1_EXT_FLAG_BIT = 11;
    localparam int TPP_GIGABIT_BIT = 1;
    localparam int TPP_FAST_BIT = 0;

    // ------------------------------------------------------------
    // Reset values and fixed capability flags
    // ------------------------------------------------------------
    localparam logic [5:0] TPP_TYPE_RESET = 6'h3d;
    localparam logic TPP_TXOFF_RESET = 1'b0;
    localparam logic TPP_T1_EXT_CAPABILITY_FLAG = 1'b1;
    localparam logic TPP_GIGABIT_T1_CAPABLE = 1'b1;
    localparam logic TPP_FAST_T1_CAPABLE = 1'b0;
    localparam logic [15:0] TPP_EXT_CAP_TWO_VALUE = 16'h0800;
    localparam logic [15:0] TPP_T1_EXT_CAP_VALUE = 16'h0002;
    localparam logic [15:0] TPP_ZERO_WORD = 16'h0000;

endpackage

// *** hw/tpp_regs.sv ***
`timescale 1ns/10ps
module tpp_regs (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Register port
    input wire logic [tpp_pkg::TPP_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [tpp_pkg::TPP_DATA_W-1:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [tpp_pkg::TPP_DATA_W-1:0] reg_rd_data,
    output logic reg_rd_valid,
    // Control outputs to the PMA/PMD
    output logic pmd_reset,
    output logic tx_disable,
    output logic [tpp_pkg::TPP_TYPE_W-1:0] pma_type_select
);
    import tpp_pkg::*;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------

    // True when the address names the given register in device space
    function automatic logic addr_is(input logic [15:0] addr, input logic [15:0] target);
        addr_is = (addr[15:12] == TPP_SPACE_NIBBLE) && (addr == target);
    endfunction

    logic wr_ctrl_one;
    logic wr_ctrl_two;
    logic wr_txoff;
    logic [15:0] rd_word;

    // Write strobes per register; capability registers have none
    assign wr_ctrl_one = reg_wr_en && addr_is(reg_addr, TPP_ADDR_CONTROL_ONE);
    assign wr_ctrl_two = reg_wr_en && addr_is(reg_addr, TPP_ADDR_CONTROL_TWO);
    assign wr_txoff = reg_wr_en && addr_is(reg_addr, TPP_ADDR_TRANSMIT_OFF);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic pmd_reset_reg;
    logic tx_off_reg;
    logic [5:0] type_sel_reg;
    logic [15:0] rd_data_reg;
    logic rd_valid_reg;

    // Self-clearing PMA/PMD reset: high for one cycle per write of one
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pmd_reset_reg <= 1'b0;
        end else begin
            pmd_reset_reg <= wr_ctrl_one && reg_wr_data[TPP_RESET_BIT];
        end
    end

    // Type selection field; the PMA/PMD reset takes priority over a write
    always_ff @(posedge sys_clk) begin
        if (srst || pmd_reset_reg) begin
            type_sel_reg <= TPP_TYPE_RESET;
        end else if (wr_ctrl_two) begin
            type_sel_reg <= reg_wr_data[TPP_TYPE_MSB:TPP_TYPE_LSB];
        end
    end

    // Transmit-off bit; upper bits of the write are dropped
    always_ff @(posedge sys_clk) begin
        if (srst || pmd_reset_reg) begin
            tx_off_reg <= TPP_TXOFF_RESET;
        end else if (wr_txoff) begin
            tx_off_reg <= reg_wr_data[TPP_TXOFF_BIT];
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------

    // Assemble the read word; reserved bits and unmapped addresses give zero
    always_comb begin
        rd_word = TPP_ZERO_WORD;
        if (addr_is(reg_addr, TPP_ADDR_CONTROL_ONE)) begin
            rd_word[TPP_RESET_BIT] = pmd_reset_reg;
        end else if (addr_is(reg_addr, TPP_ADDR_CONTROL_TWO)) begin
            rd_word[TPP_TYPE_MSB:TPP_TYPE_LSB] = type_sel_reg;
        end else if (addr_is(reg_addr, TPP_ADDR_TRANSMIT_OFF)) begin
            rd_word[TPP_TXOFF_BIT] = tx_off_reg;
        end else if (addr_is(reg_addr, TPP_ADDR_EXT_CAP_TWO)) begin
            rd_word[TPP_T1_EXT_FLAG_BIT] = TPP_T1_EXT_CAPABILITY_FLAG;
        end else if (addr_is(reg_addr, TPP_ADDR_T1_EXT_CAP)) begin
            rd_word[TPP_GIGABIT_BIT] = TPP_GIGABIT_T1_CAPABLE;
            rd_word[TPP_FAST_BIT] = TPP_FAST_T1_CAPABLE;
        end
    end

    // Registered read data, captured on each read request
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rd_data_reg <= TPP_ZERO_WORD;
        end else if (reg_rd_en) begin
            rd_data_reg <= rd_word;
        end
    end

    // Read valid pulses one cycle after the request
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= reg_rd_en;
        end
    end

    // Outputs
    assign reg_rd_data = rd_data_reg;
    assign reg_rd_valid = rd_valid_reg;
    assign pmd_reset = pmd_reset_reg;
    assign tx_disable = tx_off_reg;
    assign pma_type_select = type_sel_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    // Write of one to the reset bit
    sequence s_reset_write;
        wr_ctrl_one && reg_wr_data[TPP_RESET_BIT];
    endsequence

    // A single reset write not followed by another
    sequence s_lone_reset_write;
        s_reset_write ##1 !(wr_ctrl_one && reg_wr_data[TPP_RESET_BIT]);
    endsequence

    // Read request to a given register
    sequence s_read_of(logic [15:0] target);
        reg_rd_en && addr_is(reg_addr, target);
    endsequence

    // Reset pulse rises after the write
    a_reset_pulse_rise: assert property (s_reset_write |=> pmd_reset_reg)
        else $error("reset bit write did not pulse the PMA/PMD reset");

    // Reset pulse clears itself
    a_reset_self_clear: assert property (s_lone_reset_write |=> !pmd_reset_reg)
        else $error("PMA/PMD reset did not self clear");

    // Type selection takes written value
    a_type_write_hold: assert property (
        (wr_ctrl_two && !pmd_reset_reg) |=>
            (type_sel_reg == $past(reg_wr_data[TPP_TYPE_MSB:TPP_TYPE_LSB]))
    ) else $error("type selection did not take written value");

    // Transmit-off takes bit zero of the write
    a_txoff_write_hold: assert property (
        (wr_txoff && !pmd_reset_reg) |=> (tx_disable == $past(reg_wr_data[TPP_TXOFF_BIT]))
    ) else $error("transmit off bit did not take written value");

    // PMA/PMD reset restores writable fields
    a_fields_reset_value: assert property (
        pmd_reset_reg |=> (pma_type_select == TPP_TYPE_RESET) && (tx_disable == TPP_TXOFF_RESET)
    ) else $error("writable fields not restored by PMA/PMD reset");

    // Writable fields hold without a write; the edge that applies a device reset is left out
    a_fields_hold_stable: assert property (
        (!srst && !wr_ctrl_two && !wr_txoff && !pmd_reset_reg) |=>
            $stable(type_sel_reg) && $stable(tx_off_reg)
    ) else $error("writable field changed without a write");

    // Extended capability two reads its fixed word
    a_ext_two_value: assert property (
        s_read_of(TPP_ADDR_EXT_CAP_TWO) |=>
            reg_rd_valid && (reg_rd_data == TPP_EXT_CAP_TWO_VALUE)
    ) else $error("extended capability two read wrong value");

    // T1 extended capability reads its fixed word
    a_t1_ext_value: assert property (
        s_read_of(TPP_ADDR_T1_EXT_CAP) |=>
            reg_rd_valid && (reg_rd_data == TPP_T1_EXT_CAP_VALUE)
    ) else $error("T1 extended capability read wrong value");

    // Reserved bits of control two read zero
    a_ctrl_two_reserved: assert property (
        s_read_of(TPP_ADDR_CONTROL_TWO) |=> (reg_rd_data[15:6] == 10'h000)
    ) else $error("control two reserved bits not zero");

    // Read valid only follows a request
    a_rd_valid_cause: assert property (reg_rd_valid |-> $past(reg_rd_en))
        else $error("read valid without a request");

endmodule // tpp_regs

// *** tb/tpp_mgmt_model.sv ***
`timescale 1ns/10ps
// Management controller: one access at a time, strobe held for one edge
module tpp_mgmt_model (
    // Clock
    input wire logic sys_clk,
    // Register port
    output logic [15:0] reg_addr,
    output logic reg_wr_en,
    output logic [15:0] reg_wr_data,
    output logic reg_rd_en,
    input wire logic [15:0] reg_rd_data,
    input wire logic reg_rd_valid
);
    // Idle port at time zero
    initial begin
        reg_addr = 16'h0000;
        reg_wr_en = 1'b0;
        reg_wr_data = 16'h0000;
        reg_rd_en = 1'b0;
    end
    // One access; a read waits at most four edges for its answer
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] q);
        q = 16'hxxxx;
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr_en <= wr;
        reg_rd_en <= !wr;
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
        reg_rd_en <= 1'b0;
        reg_addr <= ~a; // Released lines show no stale value
        reg_wr_data <= ~d;
        for (int i = 0; i < 4 && !wr; i++) begin
            @(posedge sys_clk);
            if (reg_rd_valid === 1'b1) begin
                q = reg_rd_data;
                break;
            end
        end
    endtask
endmodule // tpp_mgmt_model

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
    import tpp_pkg::*;
    logic sys_clk, srst, reg_wr_en, reg_rd_en, reg_rd_valid, pmd_reset, tx_disable;
    logic [15:0] reg_addr, reg_wr_data, reg_rd_data, q;
    logic [5:0] pma_type_select;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 400) begin
            n_errors++;
            wrap_up();
        end
    end
    tpp_regs dut_u (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
        .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .pmd_reset(pmd_reset),
        .tx_disable(tx_disable), .pma_type_select(pma_type_select));
    tpp_mgmt_model mgmt_u (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid));
    // Compare helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] v;
        mgmt_u.xfer(1'b0, a, 16'h0000, v);
        chk(v, exp);
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        mgmt_u.xfer(1'b1, a, d, q);
    endtask
    task automatic outs(input logic [5:0] ty, input logic tx);
        #1;
        chk({10'h000, pma_type_select}, {10'h000, ty});
        chk({15'h0000, tx_disable}, {15'h0000, tx});
    endtask
    // Values seen right after reset
    task automatic t_reset_values();
        outs(6'h3d, 1'b0);
        rd_chk(TPP_ADDR_CONTROL_ONE, 16'h0000);
        rd_chk(TPP_ADDR_CONTROL_TWO, 16'h003d);
        rd_chk(TPP_ADDR_TRANSMIT_OFF, 16'h0000);
        rd_chk(TPP_ADDR_EXT_CAP_TWO, 16'h0800);
        rd_chk(TPP_ADDR_T1_EXT_CAP, 16'h0002);
        $display("test reset_values done");
    endtask
    // Writable fields masked, fixed flags and stray addresses ignored
    task automatic t_write_masks();
        wr(TPP_ADDR_CONTROL_TWO, 16'hffd2);
        outs(6'h12, 1'b0);
        rd_chk(TPP_ADDR_CONTROL_TWO, 16'h0012);
        wr(TPP_ADDR_TRANSMIT_OFF, 16'hffff);
        outs(6'h12, 1'b1);
        rd_chk(TPP_ADDR_TRANSMIT_OFF, 16'h0001);
        wr(TPP_ADDR_EXT_CAP_TWO, 16'hf7ff);
        wr(TPP_ADDR_T1_EXT_CAP, 16'hfffd);
        wr(16'h0007, 16'h0000);
        wr(TPP_ADDR_CONTROL_ONE, 16'h7fff);
        rd_chk(TPP_ADDR_EXT_CAP_TWO, 16'h0800);
        rd_chk(TPP_ADDR_T1_EXT_CAP, 16'h0002);
        rd_chk(16'h0007, 16'h0000);
        outs(6'h12, 1'b1);
        $display("test write_masks done");
    endtask
    // Self-clearing PMA/PMD reset restores writable fields
    task automatic t_pmd_reset();
        wr(TPP_ADDR_CONTROL_ONE, 16'h8000);
        #1;
        chk({15'h0000, pmd_reset}, 16'h0001);
        @(posedge sys_clk);
        #1;
        chk({15'h0000, pmd_reset}, 16'h0000);
        outs(6'h3d, 1'b0);
        rd_chk(TPP_ADDR_CONTROL_ONE, 16'h0000);
        $display("test pmd_reset done");
    endtask
    // Device reset in mid-run
    task automatic t_dev_reset();
        wr(TPP_ADDR_CONTROL_TWO, 16'h0021);
        wr(TPP_ADDR_TRANSMIT_OFF, 16'h0001);
        outs(6'h21, 1'b1);
        @(posedge sys_clk);
        srst <= 1'b1;
        @(posedge sys_clk);
        srst <= 1'b0;
        outs(6'h3d, 1'b0);
        rd_chk(TPP_ADDR_CONTROL_TWO, 16'h003d);
        rd_chk(TPP_ADDR_TRANSMIT_OFF, 16'h0000);
        $display("test dev_reset done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        srst = 1'b1;
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        t_reset_values();
        t_write_masks();
        t_pmd_reset();
        t_dev_reset();
        wrap_up();
    end
endmodule // tb_top
